// ===== mdc_mode_control.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - with clock-halt enable set, stop the transmit clock during transmit idle
// - clock-halt enable does nothing while the link runs at 100 Mbps
// - energy efficient enable turns low-power operation on and off
// - low-power idle requests go out even with transmitter disabled
// - low-power idle indications are decoded even with receiver disabled
// - auto exit enable leaves low-power idle after the programmed delay; a zero delay never exits
// - the exit delay counts from the start of low-power idle signalling
// - duplex polarity picks which indicator level means full duplex, resets to one
// - auto duplex ignores duplex select and follows the phy indicator
// - auto duplex writes the latest detected duplex into duplex select
// - without auto duplex, duplex select sets the operating duplex
// - low-power, duplex polarity and auto duplex fields survive soft resets when protection is set
module mdc_mode_control
  import mdc_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic soft_reset, // soft reset pulse, pclk domain
  input wire logic reset_protect, // keep protected fields over soft reset
  input wire logic speed_is_100, // link at 100 Mbps, pclk domain
  input wire logic full_duplex_indicator, // phy duplex pin, async
  output logic full_duplex_mode, // operating duplex, 1 is full
  output logic transmitter_enable, // tx enable to mac
  output logic receiver_enable, // rx enable to mac
  input wire logic link_clk, // transmit link clock
  input wire logic tx_lpi_req, // mac wants idle, link domain
  input wire logic [31:0] idle_auto_exit_delay, // exit delay, link cycles
  input wire logic rx_lpi_indication, // phy idle indication, async
  output logic tx_lpi_assert, // idle signalling to phy
  output logic gtx_clk_enable, // low halts the transmit clock
  output logic rx_lpi_detect // decoded receive idle
);

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
    is_addr = (a[11:2] == r[11:2]);
  endfunction : is_addr

  mdc_ctrl_s ctrl;
  mdc_stat_s stat;
  logic dpx_meta;
  logic dpx_sync;
  logic detected_full;
  logic wr_ctrl;
  logic setup;
  logic mapped;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  assign setup = psel && !penable;
  assign wr_ctrl = psel && penable && pready && pwrite && is_addr(paddr, MODE_CTRL_ADDR);
  assign mapped = is_addr(paddr, MODE_CTRL_ADDR) || is_addr(paddr, STATUS_ADDR);
  assign pready = 1'b1;

  // duplex pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dpx_meta <= 1'b0;
      dpx_sync <= 1'b0;
    end else begin
      dpx_meta <= full_duplex_indicator;
      dpx_sync <= dpx_meta;
    end
  end

  assign detected_full = ctrl.duplex_indicator_polarity ? dpx_sync : !dpx_sync;

  // protected fields: restored by soft reset only when unprotected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.tx_clock_halt_in_idle_enable <= RST_CLK_STOP;
      ctrl.energy_efficient_enable <= RST_EEE_EN;
      ctrl.idle_auto_exit_enable <= RST_AUTO_EXIT;
      ctrl.duplex_indicator_polarity <= RST_ADP;
      ctrl.auto_duplex_enable <= RST_ADD;
    end else if (soft_reset && !reset_protect) begin
      ctrl.tx_clock_halt_in_idle_enable <= RST_CLK_STOP;
      ctrl.energy_efficient_enable <= RST_EEE_EN;
      ctrl.idle_auto_exit_enable <= RST_AUTO_EXIT;
      ctrl.duplex_indicator_polarity <= RST_ADP;
      ctrl.auto_duplex_enable <= RST_ADD;
    end else if (wr_ctrl) begin
      ctrl.tx_clock_halt_in_idle_enable <= pwdata[CLK_STOP_BIT];
      ctrl.energy_efficient_enable <= pwdata[EEE_EN_BIT];
      ctrl.idle_auto_exit_enable <= pwdata[AUTO_EXIT_BIT];
      ctrl.duplex_indicator_polarity <= pwdata[ADP_BIT];
      ctrl.auto_duplex_enable <= pwdata[ADD_BIT];
    end
  end

  // unprotected fields: any soft reset restores them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.transmitter_enable_bit <= RST_TRANSMITTER_ENABLE_BIT;
      ctrl.receiver_enable_bit <= RST_RECEIVER_ENABLE_BIT;
    end else if (soft_reset) begin
      ctrl.transmitter_enable_bit <= RST_TRANSMITTER_ENABLE_BIT;
      ctrl.receiver_enable_bit <= RST_RECEIVER_ENABLE_BIT;
    end else if (wr_ctrl) begin
      ctrl.transmitter_enable_bit <= pwdata[TRANSMITTER_ENABLE_BIT_BIT];
      ctrl.receiver_enable_bit <= pwdata[RECEIVER_ENABLE_BIT_BIT];
    end
  end

  // detected duplex wins over a software write while auto detection is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.duplex_select <= RST_DPX;
    end else if (ctrl.auto_duplex_enable) begin
      ctrl.duplex_select <= detected_full;
    end else if (soft_reset) begin
      ctrl.duplex_select <= RST_DPX;
    end else if (wr_ctrl) begin
      ctrl.duplex_select <= pwdata[DPX_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_duplex_mode <= RST_DPX;
      transmitter_enable <= RST_TRANSMITTER_ENABLE_BIT;
      receiver_enable <= RST_RECEIVER_ENABLE_BIT;
    end else begin
      if (ctrl.auto_duplex_enable) begin
        full_duplex_mode <= detected_full;
      end else begin
        full_duplex_mode <= ctrl.duplex_select;
      end
      transmitter_enable <= ctrl.transmitter_enable_bit;
      receiver_enable <= ctrl.receiver_enable_bit;
    end
  end

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CLK_STOP_BIT] = ctrl.tx_clock_halt_in_idle_enable;
    ctrl_word[EEE_EN_BIT] = ctrl.energy_efficient_enable;
    ctrl_word[AUTO_EXIT_BIT] = ctrl.idle_auto_exit_enable;
    ctrl_word[ADP_BIT] = ctrl.duplex_indicator_polarity;
    ctrl_word[ADD_BIT] = ctrl.auto_duplex_enable;
    ctrl_word[DPX_BIT] = ctrl.duplex_select;
    ctrl_word[TRANSMITTER_ENABLE_BIT_BIT] = ctrl.transmitter_enable_bit;
    ctrl_word[RECEIVER_ENABLE_BIT_BIT] = ctrl.receiver_enable_bit;
    stat_word = 32'h0000_0000;
    stat_word[ST_TX_LPI_BIT] = stat.tx_lpi;
    stat_word[ST_GTX_HALT_BIT] = stat.gtx_halted;
    stat_word[ST_RX_LPI_BIT] = stat.rx_lpi;
    stat_word[ST_FULL_DPX_BIT] = stat.full_duplex;
  end

  // read data and error captured in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      if (pwrite || !mapped) begin
        prdata <= 32'h0000_0000;
      end else if (is_addr(paddr, MODE_CTRL_ADDR)) begin
        prdata <= ctrl_word;
      end else begin
        prdata <= stat_word;
      end
    end
  end

  // link-domain reset: async assert, synchronous release
  logic lrst_meta;
  logic lrst_n;
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_meta <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n <= lrst_meta;
    end
  end

  // control levels into the link domain; quasi-static by software convention
  logic [3:0] lcfg_meta;
  logic [3:0] lcfg;
  logic l_eee_en;
  logic l_auto_exit;
  logic l_clk_stop;
  logic l_speed100;
  logic rxi_meta;
  logic rxi_sync;
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lcfg_meta <= 4'h0;
      lcfg <= 4'h0;
      rxi_meta <= 1'b0;
      rxi_sync <= 1'b0;
    end else begin
      lcfg_meta <= {ctrl.energy_efficient_enable, ctrl.idle_auto_exit_enable,
                    ctrl.tx_clock_halt_in_idle_enable, speed_is_100};
      lcfg <= lcfg_meta;
      rxi_meta <= rx_lpi_indication;
      rxi_sync <= rxi_meta;
    end
  end
  assign l_eee_en = lcfg[3];
  assign l_auto_exit = lcfg[2];
  assign l_clk_stop = lcfg[1];
  assign l_speed100 = lcfg[0];

  mdc_lpi_e lpi_state;
  mdc_lpi_e next_lpi_state;
  logic [31:0] exit_delay;
  logic [31:0] exit_count;
  logic exit_due;

  assign exit_due = l_auto_exit && (exit_count >= exit_delay) && (exit_delay != DELAY_ZERO);

  // transmit idle does not depend on the transmitter enable
  always_comb begin
    next_lpi_state = lpi_state;
    case (lpi_state)
      LPI_OFF: begin
        if (l_eee_en && tx_lpi_req) begin
          next_lpi_state = LPI_ON;
        end
      end
      LPI_ON: begin
        if (!l_eee_en || !tx_lpi_req) begin
          next_lpi_state = LPI_OFF;
        end else if (exit_due) begin
          next_lpi_state = LPI_EXITED;
        end
      end
      LPI_EXITED: begin
        if (!l_eee_en || !tx_lpi_req) begin
          next_lpi_state = LPI_OFF;
        end
      end
      default: begin
        next_lpi_state = LPI_OFF;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lpi_state <= LPI_OFF;
    end else begin
      lpi_state <= next_lpi_state;
    end
  end

  // delay sampled and count set to one as idle signalling begins
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      exit_delay <= DELAY_ZERO;
      exit_count <= DELAY_ZERO;
    end else if (lpi_state == LPI_OFF && next_lpi_state == LPI_ON) begin
      exit_delay <= idle_auto_exit_delay;
      exit_count <= DELAY_ONE;
    end else if (lpi_state == LPI_ON && !exit_due) begin
      exit_count <= exit_count + DELAY_ONE;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      tx_lpi_assert <= 1'b0;
      gtx_clk_enable <= 1'b1;
      rx_lpi_detect <= 1'b0;
    end else begin
      tx_lpi_assert <= (next_lpi_state == LPI_ON);
      gtx_clk_enable <= !((next_lpi_state == LPI_ON) && l_clk_stop && !l_speed100);
      rx_lpi_detect <= l_eee_en && rxi_sync;
    end
  end

  // link status back to the bus domain
  logic [2:0] st_meta;
  logic [2:0] st_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_meta <= 3'h0;
      st_sync <= 3'h0;
    end else begin
      st_meta <= {rx_lpi_detect, !gtx_clk_enable, tx_lpi_assert};
      st_sync <= st_meta;
    end
  end
  assign stat.tx_lpi = st_sync[0];
  assign stat.gtx_halted = st_sync[1];
  assign stat.rx_lpi = st_sync[2];
  assign stat.full_duplex = full_duplex_mode;

endmodule : mdc_mode_control

// ===== mdc_pkg.sv
package mdc_pkg;
  localparam logic [11:0] MODE_CTRL_ADDR = 12'h100;
  localparam logic [11:0] STATUS_ADDR = 12'h104;
  localparam int RECEIVER_ENABLE_BIT_BIT = 0;
  localparam int TRANSMITTER_ENABLE_BIT_BIT = 1;
  localparam int DPX_BIT = 3;
  localparam int ADD_BIT = 12;
  localparam int ADP_BIT = 13;
  localparam int AUTO_EXIT_BIT = 16;
  localparam int EEE_EN_BIT = 17;
  localparam int CLK_STOP_BIT = 18;
  localparam int ST_TX_LPI_BIT = 0;
  localparam int ST_GTX_HALT_BIT = 1;
  localparam int ST_RX_LPI_BIT = 2;
  localparam int ST_FULL_DPX_BIT = 3;
  localparam logic RST_RECEIVER_ENABLE_BIT = 1'b0;
  localparam logic RST_TRANSMITTER_ENABLE_BIT = 1'b0;
  localparam logic RST_DPX = 1'b0;
  localparam logic RST_ADD = 1'b0;
  localparam logic RST_ADP = 1'b1;
  localparam logic RST_AUTO_EXIT = 1'b0;
  localparam logic RST_EEE_EN = 1'b0;
  localparam logic RST_CLK_STOP = 1'b0;
  localparam logic [31:0] DELAY_ZERO = 32'h0000_0000;
  localparam logic [31:0] DELAY_ONE = 32'h0000_0001;

  typedef struct packed {
    logic tx_clock_halt_in_idle_enable;
    logic energy_efficient_enable;
    logic idle_auto_exit_enable;
    logic duplex_indicator_polarity;
    logic auto_duplex_enable;
    logic duplex_select;
    logic transmitter_enable_bit;
    logic receiver_enable_bit;
  } mdc_ctrl_s;

  typedef struct packed {
    logic full_duplex;
    logic rx_lpi;
    logic gtx_halted;
    logic tx_lpi;
  } mdc_stat_s;

  typedef enum logic [1:0] {
    LPI_OFF = 2'b00,
    LPI_ON = 2'b01,
    LPI_EXITED = 2'b10
  } mdc_lpi_e;
endpackage : mdc_pkg

// ===== mdc_mode_control_sva.sv
`timescale 1ns/10ps
module mdc_mode_control_sva
  import mdc_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // error
  input wire logic soft_reset, // soft reset
  input wire logic speed_is_100, // slow link
  input wire logic transmitter_enable, // tx on
  input wire logic receiver_enable, // rx on
  input wire logic link_clk, // link clock
  input wire logic tx_lpi_req, // idle request
  input wire logic rx_lpi_indication, // phy idle
  input wire logic tx_lpi_assert, // idle out
  input wire logic gtx_clk_enable, // clock gate
  input wire logic rx_lpi_detect // idle seen
);
  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && paddr != MODE_CTRL_ADDR && paddr != STATUS_ADDR |-> pslverr
    && prdata == '0) else $error("unmapped access not refused");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == MODE_CTRL_ADDR |-> !pslverr
    && prdata[31:19] == '0 && prdata[15:14] == '0) else $error("reserved bits set");
  a_soft_clear_en: assert property (@(posedge pclk) disable iff (!presetn)
    soft_reset |-> ##2 !transmitter_enable && !receiver_enable) else $error("enables kept");
  a_halt_in_idle: assert property (@(posedge link_clk) disable iff (!presetn)
    !gtx_clk_enable |-> tx_lpi_assert) else $error("clock halted outside idle");
  a_no_halt_slow: assert property (@(posedge link_clk) disable iff (!presetn)
    speed_is_100 [*4] |-> !$fell(gtx_clk_enable)) else $error("halt at slow speed");
  a_idle_needs_req: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(tx_lpi_assert) |-> $past(tx_lpi_req)) else $error("idle without request");
  a_idle_ends: assert property (@(posedge link_clk) disable iff (!presetn)
    tx_lpi_assert && !tx_lpi_req |-> ##[1:2] !tx_lpi_assert) else $error("idle held");
  a_rx_idle_off: assert property (@(posedge link_clk) disable iff (!presetn)
    !rx_lpi_indication [*4] |-> !rx_lpi_detect) else $error("false receive idle");
  a_rx_idle_on: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(rx_lpi_detect) |-> $past(rx_lpi_indication, 3)) else $error("idle too early");
endmodule : mdc_mode_control_sva

bind mdc_mode_control mdc_mode_control_sva mdc_mode_control_sva_i (.*);

// ===== mdc_phy_model.sv
`timescale 1ns/10ps
module mdc_phy_model (
  input wire logic link_clk, // link clock
  input wire logic full_want, // phy in full duplex
  input wire logic pin_active_high, // indicator polarity
  input wire logic idle_want, // phy in receive idle
  output logic full_duplex_indicator, // duplex pin
  output logic rx_lpi_indication // receive idle pin
);
  assign full_duplex_indicator = pin_active_high ? full_want : !full_want;
  always_ff @(posedge link_clk) begin
    rx_lpi_indication <= idle_want;
  end
endmodule : mdc_phy_model

// ===== test_mac_eee_duplex_control.sv
`timescale 1ns/10ps
module test_mac_eee_duplex_control;
  import mdc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, soft_reset, reset_protect, speed_is_100;
  logic link_clk, tx_lpi_req, full_want, pin_active_high, idle_want, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, idle_auto_exit_delay, rd, mdl;
  logic pready, pslverr, full_duplex_indicator, rx_lpi_indication, full_duplex_mode;
  logic transmitter_enable, receiver_enable, tx_lpi_assert, gtx_clk_enable, rx_lpi_detect;
  logic [15:0] lfsr;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int hi, hl, d;

  mdc_mode_control mdc_mode_control_i (.*);
  mdc_phy_model mdc_phy_model_i (.*);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tally_and_finish();
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, soft_reset, reset_protect} = '0;
    {speed_is_100, tx_lpi_req, full_want, idle_want, presetn} = '0;
    pin_active_high = 1'b1;
    idle_auto_exit_delay = 32'h6;
    lfsr = 16'h6;
    mdl = 32'h0000_2000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MODE_CTRL_ADDR, '0);
    cmp(rd, mdl);
    cmp({31'b0, pready}, 32'h1);
    $display("reset value test done");
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      mdl = ({lfsr, ~lfsr} & 32'h0006_000b) | 32'h2000;
      apb(1'b1, MODE_CTRL_ADDR, {lfsr, ~lfsr} & 32'hfffe_cfff | 32'h2000);
      apb(1'b0, MODE_CTRL_ADDR, '0);
      cmp(rd, mdl);
      cmp({29'b0, full_duplex_mode, transmitter_enable, receiver_enable},
          {29'b0, mdl[3], mdl[1:0]});
    end
    apb(1'b1, 12'h108, '1);
    cmp({31'b0, err}, 32'h1);
    apb(1'b0, MODE_CTRL_ADDR, '0);
    cmp(rd, mdl);
    $display("register access test done");
    apb(1'b1, MODE_CTRL_ADDR, 32'h0000_2000);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, MODE_CTRL_ADDR, 32'h0000_1000 | (p << 13));
      pin_active_high <= p[0];
      for (int f = 0; f < 2; f++) begin
        full_want <= f[0];
        repeat (6) @(posedge pclk);
        apb(1'b0, MODE_CTRL_ADDR, '0);
        cmp({31'b0, full_duplex_mode}, f);
        cmp(rd, 32'h0000_1000 | (p << 13) | (f << 3));
      end
    end
    apb(1'b1, MODE_CTRL_ADDR, 32'h0000_2000);
    $display("auto duplex test done");
    apb(1'b1, MODE_CTRL_ADDR, 32'h0001_2000);
    apb(1'b1, MODE_CTRL_ADDR, 32'h0007_2000);
    for (int s = 0; s < 2; s++) begin
      speed_is_100 <= s[0];
      d = s ? 3 : 6;
      @(posedge link_clk);
      idle_auto_exit_delay <= d;
      repeat (4) @(posedge link_clk);
      tx_lpi_req <= 1'b1;
      hi = 0;
      hl = 0;
      for (int k = 0; k < 20; k++) begin
        @(posedge link_clk);
        if (k == 3) idle_auto_exit_delay <= 32'h40;
        hi += tx_lpi_assert;
        hl += !gtx_clk_enable;
      end
      tx_lpi_req <= 1'b0;
      cmp({31'b0, hi >= d - 1 && hi <= d + 1}, 32'h1);
      cmp(hl, s ? 0 : hi);
    end
    idle_want <= 1'b1;
    repeat (6) @(posedge link_clk);
    cmp({31'b0, rx_lpi_detect}, 32'h1);
    apb(1'b0, STATUS_ADDR, '0);
    cmp(rd, 32'h0000_0004);
    apb(1'b1, MODE_CTRL_ADDR, 32'h0001_2000);
    tx_lpi_req <= 1'b1;
    repeat (6) @(posedge link_clk);
    cmp({30'b0, tx_lpi_assert, rx_lpi_detect}, 32'h0);
    tx_lpi_req <= 1'b0;
    idle_want <= 1'b0;
    $display("low power idle test done");
    apb(1'b1, MODE_CTRL_ADDR, 32'h0007_0003);
    for (int p = 1; p >= 0; p--) begin
      reset_protect <= p[0];
      soft_reset <= 1'b1;
      @(posedge pclk);
      soft_reset <= 1'b0;
      apb(1'b0, MODE_CTRL_ADDR, '0);
      cmp(rd, p ? 32'h0007_0000 : 32'h0000_2000);
    end
    $display("soft reset test done");
    tally_and_finish();
  end
endmodule : test_mac_eee_duplex_control
